//--- src/usb_ram_defines.svh
// Constants for the shared endpoint buffer memory and its two ends.
// Included by the package, both end modules and the testbench.
`ifndef USB_RAM_DEFINES_SVH
`define USB_RAM_DEFINES_SVH

// Buffer memory geometry
`define RAM_BYTES      256
`define RAM_AW         8
`define BD_BYTES       8'h03
`define BD_COUNT       4'hA
`define BD_NONE        4'hF
`define BD_TABLE_END   8'h1D
`define EP_BUF_BASE    8'h20
`define BD_OWN_BIT     7

// Firmware-side software port map
`define SW_AW          9
`define SW_REG_BIT     8
`define SW_CTRL_OFS    9'h100
`define SW_STAT_OFS    9'h101
`define SW_TOKEN_OFS   9'h102
`define SW_SIEADR_OFS  9'h103
`define SW_SIEDAT_OFS  9'h104
`define SW_BDSEL_OFS   9'h105

// Control register fields
`define CTRL_USB_EN    0
`define CTRL_PULLUP    1
`define CTRL_SELF_PWR  2
`define CTRL_TRANSCEIVER_REGULATOR_EN   3
`define CTRL_SUSPEND   4
`define CTRL_DEEP_STOP 5
`define CTRL_RESET     8'h00

// Token register fields
`define TOK_EP_LSB     0
`define TOK_OUT        3
`define TOK_ODD        4
`define TOK_RELEASE    7

// Status register fields
`define STAT_PULLUP    0
`define STAT_MODE_LSB  1
`define STAT_TOK_OWN   3
`define STAT_TOK_BAD   4
`define STAT_VBUS_PIN  5
`define STAT_STOP_LSB  6

`endif

//--- src/usb_ram_pkg.sv
// Types shared by the buffer memory device end and the firmware end.
// Needs usb_ram_defines.svh on the include path.
`include "usb_ram_defines.svh"

package usb_ram_pkg;
    typedef enum logic [1:0] {REG_OFF, REG_STANDBY, REG_ACTIVE} reg_mode_t;
    typedef enum logic [1:0] {STOP_RUN, STOP_SHALLOW, STOP_DEEPEST}
        stop_mode_t;
    typedef logic [`RAM_AW-1:0] ram_addr_t;
    typedef logic [7:0]         byte_t;
endpackage

//--- src/usb_ram_if.sv
// Link between the buffer memory device end and the firmware end.
// Both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface usb_ram_if;
    import usb_ram_pkg::*;
    // CPU peripheral-bus port
    logic      cpu_req;
    logic      cpu_we;
    ram_addr_t cpu_addr;
    byte_t     cpu_wdata;
    byte_t     cpu_rdata;
    // Serial engine data port
    logic      sie_req;
    logic      sie_we;
    logic      sie_bd;
    ram_addr_t sie_addr;
    byte_t     sie_wdata;
    byte_t     sie_rdata;
    logic      sie_gnt;
    // Serial engine token lookup
    logic      tok_valid;
    logic [2:0] tok_ep;
    logic      tok_out;
    logic      tok_odd;
    logic      tok_release;
    logic      tok_done;
    logic      tok_own;
    logic      tok_bad;
    // Module and power control
    logic      usb_en;
    logic      pullup_sel;
    logic      self_pwr;
    logic      transceiver_regulator_en;
    logic      suspend;
    logic      deep_stop;
    logic      pullup_on;
    reg_mode_t reg_mode;

    modport dev (
        input  cpu_req, cpu_we, cpu_addr, cpu_wdata,
        input  sie_req, sie_we, sie_bd, sie_addr, sie_wdata,
        input  tok_valid, tok_ep, tok_out, tok_odd, tok_release,
        input  usb_en, pullup_sel, self_pwr, transceiver_regulator_en, suspend, deep_stop,
        output cpu_rdata, sie_rdata, sie_gnt, tok_done, tok_own, tok_bad,
        output pullup_on, reg_mode
    );
    modport fw (
        output cpu_req, cpu_we, cpu_addr, cpu_wdata,
        output sie_req, sie_we, sie_bd, sie_addr, sie_wdata,
        output tok_valid, tok_ep, tok_out, tok_odd, tok_release,
        output usb_en, pullup_sel, self_pwr, transceiver_regulator_en, suspend, deep_stop,
        input  cpu_rdata, sie_rdata, sie_gnt, tok_done, tok_own, tok_bad,
        input  pullup_on, reg_mode
    );
endinterface

`default_nettype wire

//--- src/usb_ram_dev.sv
// Device end: 256-byte shared endpoint buffer memory with two-slot
// arbitration, descriptor mapping, pull-up and regulator mode control.
// Assumes the firmware end drives usb_ram_if.fw on the same clock.
//
// Function
// - 256-byte memory shared by engine and CPU
// - Memory runs two accesses per bus cycle
// - Arbiter grants CPU port and serial engine
// - Descriptor requests map to physical addresses
// - Unused memory serves as system memory
// - Disabled module leaves whole memory to CPU
// - Regulator standby in suspend or module disabled, else active
// - Regulator off in deepest stop or regulator enable clear
// - Firmware enters shallow stop after bus suspend
// - Select bit connects or disconnects data pull-up
// - Pull-up only while VBUS is valid
// - Built-in VBUS sensing for bus power
// - Self-powered firmware senses VBUS, then sets bit
// - Descriptor is three bytes, control and address
// - Ownership flag 0 gives processor the buffer
// - Ownership flag 1 gives module the buffer
// - EP0 has one descriptor per direction, EP1-4 one each, EP7 none
// - Double buffering uses even then odd descriptor
// - Table at 0x00-0x1D, buffers from 0x20
// - Token reads descriptor and checks ownership
// - Module clears ownership flag after a token with release bit
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ram_defines.svh"

module usb_ram_dev (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    // Firmware and serial engine link
    usb_ram_if.dev                 link,
    // Pins and power
    input  wire logic              vbus_i,
    output logic                   pullup_en_o,
    output usb_ram_pkg::reg_mode_t reg_mode_o
);
    import usb_ram_pkg::*;

    byte_t      mem [0:`RAM_BYTES-1];
    byte_t      cpu_rdata_q;
    byte_t      sie_rdata_q;
    logic       tok_done_q;
    logic       tok_own_q;
    logic       tok_bad_q;
    logic [2:0] vbus_sync_q;
    logic       vbus_ok_q;
    logic       pullup_q;
    reg_mode_t  reg_mode_q;
    logic [3:0] tok_idx;
    logic [3:0] sie_idx;
    logic       tok_ok;
    logic       sie_ok;
    logic       cpu_wr;
    ram_addr_t  tok_addr;
    ram_addr_t  sie_phys;
    byte_t      tok_byte;

    // Descriptor slot of an endpoint direction, BD_NONE if none exists
    function automatic logic [3:0] bd_index(
        input logic [2:0] ep,
        input logic       out,
        input logic       odd
    );
        unique case (ep)
            3'h0:    bd_index = {3'h0, out};
            3'h1,
            3'h2,
            3'h3,
            3'h4:    bd_index = {1'b0, ep} + 4'h1;
            3'h5:    bd_index = 4'h6 + {3'h0, odd};
            3'h6:    bd_index = 4'h8 + {3'h0, odd};
            default: bd_index = `BD_NONE;
        endcase
    endfunction

    // Byte address of one byte of a descriptor
    function automatic ram_addr_t bd_addr(
        input logic [3:0] idx,
        input logic [1:0] sel
    );
        bd_addr = {4'h0, idx} * `BD_BYTES + {6'h00, sel};
    endfunction

    // Byte seen in the engine slot, after the CPU slot has written
    function automatic byte_t slot2_read(input ram_addr_t a);
        if (cpu_wr && link.cpu_addr == a)
            slot2_read = link.cpu_wdata;
        else
            slot2_read = mem[a];
    endfunction

    // Engine descriptor mode: addr[3:0] is the slot, addr[5:4] the byte
    always_comb
    begin
        cpu_wr   = link.cpu_req && link.cpu_we;
        tok_idx  = bd_index(link.tok_ep, link.tok_out, link.tok_odd);
        tok_ok   = link.usb_en && link.tok_valid && tok_idx != `BD_NONE;
        tok_addr = bd_addr(tok_idx, 2'h0);
        sie_idx  = link.sie_addr[3:0];
        if (link.sie_bd)
        begin
            sie_phys = bd_addr(sie_idx, link.sie_addr[5:4]);
            sie_ok   = sie_idx < `BD_COUNT && link.sie_addr[5:4] != 2'h3;
        end
        else
        begin
            sie_phys = link.sie_addr;
            sie_ok   = 1'b1;
        end
        tok_byte = slot2_read(tok_addr);
    end

    // Engine is locked out while disabled; token lookup owns its slot
    assign link.sie_gnt = link.usb_en && !link.tok_valid
                          && sie_ok;

    // CPU writes in the first slot, engine in the second; same byte
    // written by both ends up with the engine value
    always_ff @(posedge core_clk_i)
    begin
        if (cpu_wr)
            mem[link.cpu_addr] <= link.cpu_wdata;
        if (tok_ok && link.tok_release)
            mem[tok_addr] <= tok_byte & 8'h7F;
        else if (link.sie_req && link.sie_we && link.sie_gnt)
            mem[sie_phys] <= link.sie_wdata;
    end

    // CPU reads before any write of the cycle
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            cpu_rdata_q <= 8'h00;
        else if (link.cpu_req && !link.cpu_we)
            cpu_rdata_q <= mem[link.cpu_addr];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            sie_rdata_q <= 8'h00;
        else if (link.sie_req && !link.sie_we && link.sie_gnt)
            sie_rdata_q <= slot2_read(sie_phys);
    end

    // Token lookup; hardware does not block the CPU on owned buffers
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            tok_done_q <= 1'b0;
            tok_own_q  <= 1'b0;
            tok_bad_q  <= 1'b0;
        end
        else
        begin
            tok_done_q <= link.tok_valid;
            if (link.tok_valid)
            begin
                tok_bad_q <= !tok_ok;
                tok_own_q <= tok_ok
                             && tok_byte[`BD_OWN_BIT];
            end
        end
    end

    assign link.cpu_rdata = cpu_rdata_q;
    assign link.sie_rdata = sie_rdata_q;
    assign link.tok_done  = tok_done_q;
    assign link.tok_own   = tok_own_q;
    assign link.tok_bad   = tok_bad_q;

    // VBUS pin sense; a change counts once two stages agree
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            vbus_sync_q <= 3'h0;
            vbus_ok_q   <= 1'b0;
        end
        else
        begin
            vbus_sync_q <= {vbus_sync_q[1:0], vbus_i};
            if (vbus_sync_q[1] == vbus_sync_q[2])
                vbus_ok_q <= vbus_sync_q[2];
        end
    end

    // Self-powered boards qualify the select bit in firmware
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            pullup_q <= 1'b0;
        else
            pullup_q <= link.usb_en && link.pullup_sel
                        && (link.self_pwr || vbus_ok_q);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            reg_mode_q <= REG_OFF;
        else if (link.deep_stop || !link.transceiver_regulator_en)
            reg_mode_q <= REG_OFF;
        else if (link.suspend || !link.usb_en)
            reg_mode_q <= REG_STANDBY;
        else
            reg_mode_q <= REG_ACTIVE;
    end

    assign pullup_en_o    = pullup_q;
    assign reg_mode_o     = reg_mode_q;
    assign link.pullup_on = pullup_q;
    assign link.reg_mode  = reg_mode_q;
endmodule

`default_nettype wire

//--- src/usb_ram_fw.sv
// Firmware end: software port onto the buffer memory, serial engine
// token and data accesses, power control and stop mode requests.
// Assumes the device end answers on usb_ram_if.dev one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ram_defines.svh"

module usb_ram_fw (
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    // Software port
    input  wire logic [`SW_AW-1:0]    addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 we_i,
    input  wire logic                 re_i,
    output logic      [7:0]           rdata_o,
    // Board and power
    input  wire logic                 kbi_vbus_i,
    output usb_ram_pkg::stop_mode_t   stop_mode_o,
    // Device link
    usb_ram_if.fw                     link
);
    import usb_ram_pkg::*;

    typedef enum logic [1:0] {SRC_RAM, SRC_SIE, SRC_REG} rd_src_t;

    byte_t      ctrl_q;
    byte_t      reg_rdata_q;
    ram_addr_t  sie_addr_q;
    logic       sie_bd_q;
    logic       tok_own_q;
    logic       tok_bad_q;
    logic [2:0] kbi_sync_q;
    logic       kbi_ok_q;
    rd_src_t    src_q;
    stop_mode_t stop_q;
    logic       sie_acc;
    logic       regs;
    byte_t      stat;

    assign regs    = addr_i[`SW_REG_BIT];
    assign sie_acc = (we_i || re_i) && addr_i == `SW_SIEDAT_OFS;

    // CPU port: low half of the software map is the memory itself
    assign link.cpu_req   = (we_i || re_i) && !regs;
    assign link.cpu_we    = we_i;
    assign link.cpu_addr  = addr_i[`RAM_AW-1:0];
    assign link.cpu_wdata = wdata_i;

    assign link.sie_req   = sie_acc;
    assign link.sie_we    = we_i;
    assign link.sie_bd    = sie_bd_q;
    assign link.sie_addr  = sie_addr_q;
    assign link.sie_wdata = wdata_i;

    // Firmware sets ownership last, through the CPU port
    assign link.tok_valid   = we_i && addr_i == `SW_TOKEN_OFS;
    assign link.tok_ep      = wdata_i[`TOK_EP_LSB+2:`TOK_EP_LSB];
    assign link.tok_out     = wdata_i[`TOK_OUT];
    assign link.tok_odd     = wdata_i[`TOK_ODD];
    assign link.tok_release = wdata_i[`TOK_RELEASE];

    assign link.usb_en    = ctrl_q[`CTRL_USB_EN];
    assign link.self_pwr  = ctrl_q[`CTRL_SELF_PWR];
    assign link.transceiver_regulator_en   = ctrl_q[`CTRL_TRANSCEIVER_REGULATOR_EN];
    assign link.suspend   = ctrl_q[`CTRL_SUSPEND];
    assign link.deep_stop = ctrl_q[`CTRL_DEEP_STOP];
    // Self powered: select bit only passes once the pin saw VBUS
    assign link.pullup_sel = ctrl_q[`CTRL_PULLUP]
        && (!ctrl_q[`CTRL_SELF_PWR] || kbi_ok_q);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            ctrl_q <= `CTRL_RESET;
        else if (we_i && addr_i == `SW_CTRL_OFS)
            ctrl_q <= wdata_i;
    end

    // Engine data pointer; plain addresses step after each granted access
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            sie_addr_q <= 8'h00;
            sie_bd_q   <= 1'b0;
        end
        else if (we_i && addr_i == `SW_SIEADR_OFS)
        begin
            sie_addr_q <= wdata_i;
            sie_bd_q   <= 1'b0;
        end
        else if (we_i && addr_i == `SW_BDSEL_OFS)
        begin
            sie_addr_q <= wdata_i;
            sie_bd_q   <= 1'b1;
        end
        else if (sie_acc && link.sie_gnt && !sie_bd_q)
            sie_addr_q <= sie_addr_q + 8'h01;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            tok_own_q <= 1'b0;
            tok_bad_q <= 1'b0;
        end
        else if (link.tok_done)
        begin
            tok_own_q <= link.tok_own;
            tok_bad_q <= link.tok_bad;
        end
    end

    // Board VBUS detect pin for self-powered use
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            kbi_sync_q <= 3'h0;
            kbi_ok_q   <= 1'b0;
        end
        else
        begin
            kbi_sync_q <= {kbi_sync_q[1:0], kbi_vbus_i};
            if (kbi_sync_q[1] == kbi_sync_q[2])
                kbi_ok_q <= kbi_sync_q[2];
        end
    end

    // Bus suspend puts the processor into shallow stop
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            stop_q <= STOP_RUN;
        else if (ctrl_q[`CTRL_DEEP_STOP])
            stop_q <= STOP_DEEPEST;
        else if (ctrl_q[`CTRL_SUSPEND])
            stop_q <= STOP_SHALLOW;
        else
            stop_q <= STOP_RUN;
    end

    always_comb
    begin
        stat = 8'h00;
        stat[`STAT_PULLUP]                   = link.pullup_on;
        stat[`STAT_MODE_LSB+1:`STAT_MODE_LSB] = link.reg_mode;
        stat[`STAT_TOK_OWN]                  = tok_own_q;
        stat[`STAT_TOK_BAD]                  = tok_bad_q;
        stat[`STAT_VBUS_PIN]                 = kbi_ok_q;
        stat[`STAT_STOP_LSB+1:`STAT_STOP_LSB] = stop_q;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_q <= 8'h00;
            src_q       <= SRC_REG;
        end
        else if (re_i)
        begin
            src_q <= !regs ? SRC_RAM : (sie_acc ? SRC_SIE : SRC_REG);
            unique case (addr_i)
                `SW_CTRL_OFS:   reg_rdata_q <= ctrl_q;
                `SW_STAT_OFS:   reg_rdata_q <= stat;
                `SW_SIEADR_OFS: reg_rdata_q <= sie_addr_q;
                default:        reg_rdata_q <= 8'h00;
            endcase
        end
    end

    always_comb
    begin
        unique case (src_q)
            SRC_RAM: rdata_o = link.cpu_rdata;
            SRC_SIE: rdata_o = link.sie_rdata;
            default: rdata_o = reg_rdata_q;
        endcase
    end

    assign stop_mode_o = stop_q;
endmodule

`default_nettype wire

//--- testbench/usb_ram_assertions.sv
// Checker for the link between the buffer memory device and firmware ends.
// Instanced beside the interface; sees its signals as plain inputs.
`timescale 1ns/1ps
`default_nettype none

module usb_ram_assertions (
    // Clock and reset
    input wire logic                   core_clk_i,
    input wire logic                   rst_i,
    // Token lookup and engine grant
    input wire logic                   tok_valid,
    input wire logic [2:0]             tok_ep,
    input wire logic                   tok_done,
    input wire logic                   tok_own,
    input wire logic                   tok_bad,
    input wire logic                   sie_gnt,
    input wire logic                   sie_we,
    // Power control
    input wire logic                   usb_en,
    input wire logic                   pullup_sel,
    input wire logic                   self_pwr,
    input wire logic                   transceiver_regulator_en,
    input wire logic                   suspend,
    input wire logic                   deep_stop,
    input wire logic                   pullup_on,
    input wire usb_ram_pkg::reg_mode_t reg_mode
);
    import usb_ram_pkg::*;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    AST_TOK_DONE: assert property (tok_valid && usb_en |=> tok_done)
        else $error("token lookup not answered");
    AST_TOK_CAUSE: assert property (tok_done |-> $past(tok_valid))
        else $error("token answer without token");
    AST_TOK_BAD: assert property (tok_valid && usb_en |=>
        tok_bad == ($past(tok_ep) == 3'h7))
        else $error("descriptor slot check wrong");
    AST_TOK_HOLD: assert property (!tok_valid |=>
        $stable(tok_own) && $stable(tok_bad))
        else $error("token result moved without token");
    AST_GNT_BLOCK: assert property (!usb_en || tok_valid |->
        !sie_gnt)
        else $error("engine granted while blocked");
    AST_REG_OFF: assert property (deep_stop || !transceiver_regulator_en |=>
        reg_mode == REG_OFF)
        else $error("regulator not off");
    AST_REG_STBY: assert property (transceiver_regulator_en && !deep_stop &&
        (suspend || !usb_en) |=> reg_mode == REG_STANDBY)
        else $error("regulator not in standby");
    AST_REG_ACT: assert property (transceiver_regulator_en && !deep_stop &&
        !suspend && usb_en |=> reg_mode == REG_ACTIVE)
        else $error("regulator not active");
    AST_PU_OFF: assert property (!(usb_en && pullup_sel) |=>
        !pullup_on)
        else $error("pull-up on without select");
    AST_PU_SELF: assert property (usb_en && pullup_sel &&
        self_pwr |=> pullup_on)
        else $error("self-powered pull-up not on");

    cover property (tok_done && tok_own);
    cover property (reg_mode == REG_STANDBY);
    cover property (pullup_on);
    cover property (sie_gnt && sie_we);
endmodule

`default_nettype wire

//--- testbench/tb_usb_endpoint_buffer_ram.sv
// Testbench joining the device end and the firmware end of the memory.
// Drives the software port and pins; queued reads are checked on return.
`timescale 1ns/1ps
`default_nettype none
`include "usb_ram_defines.svh"

module tb_usb_endpoint_buffer_ram;
    import usb_ram_pkg::*;

    logic       core_clk_i;
    logic       rst_i;
    logic [8:0] addr_i;
    byte_t      wdata_i;
    logic       we_i;
    logic       re_i;
    byte_t      rdata_o;
    logic       kbi_vbus_i;
    logic       vbus_i;
    logic       pullup_en_o;
    reg_mode_t  reg_mode_o;
    stop_mode_t stop_mode_o;
    logic       rd_pend;
    byte_t      exp_q[$];
    byte_t      mem[256];
    byte_t      addrs[32];
    byte_t      e;
    byte_t      b;
    int         s;
    int         error_cnt;
    int         total_checks;
    integer     seed;

    usb_ram_if usb_ram_if_i ();

    usb_ram_dev usb_ram_dev_i (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .link        (usb_ram_if_i.dev),
        .vbus_i      (vbus_i),
        .pullup_en_o (pullup_en_o),
        .reg_mode_o  (reg_mode_o)
    );

    usb_ram_fw usb_ram_fw_i (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .addr_i      (addr_i),
        .wdata_i     (wdata_i),
        .we_i        (we_i),
        .re_i        (re_i),
        .rdata_o     (rdata_o),
        .kbi_vbus_i  (kbi_vbus_i),
        .stop_mode_o (stop_mode_o),
        .link        (usb_ram_if_i.fw)
    );

    usb_ram_assertions usb_ram_assertions_i (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .tok_valid  (usb_ram_if_i.tok_valid),
        .tok_ep     (usb_ram_if_i.tok_ep),
        .tok_done   (usb_ram_if_i.tok_done),
        .tok_own    (usb_ram_if_i.tok_own),
        .tok_bad    (usb_ram_if_i.tok_bad),
        .sie_gnt    (usb_ram_if_i.sie_gnt),
        .sie_we     (usb_ram_if_i.sie_we),
        .usb_en     (usb_ram_if_i.usb_en),
        .pullup_sel (usb_ram_if_i.pullup_sel),
        .self_pwr   (usb_ram_if_i.self_pwr),
        .transceiver_regulator_en    (usb_ram_if_i.transceiver_regulator_en),
        .suspend    (usb_ram_if_i.suspend),
        .deep_stop  (usb_ram_if_i.deep_stop),
        .pullup_on  (usb_ram_if_i.pullup_on),
        .reg_mode   (usb_ram_if_i.reg_mode)
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            error_cnt++;
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [8:0] a, input byte_t d);
        addr_i  <= a;
        wdata_i <= d;
        we_i    <= 1'b1;
        re_i    <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rd(input logic [8:0] a, input byte_t x);
        exp_q.push_back(x);
        addr_i <= a;
        we_i   <= 1'b0;
        re_i   <= 1'b1;
        @(posedge core_clk_i);
    endtask

    task automatic idle(input int n);
        we_i <= 1'b0;
        re_i <= 1'b0;
        repeat (n) @(posedge core_clk_i);
    endtask

    // Expected status byte from control bits, pins and token result
    function automatic byte_t stat_exp(input byte_t c, input logic vb,
                                       input logic kb, input logic [1:0] tk);
        logic       sel;
        reg_mode_t  m;
        stop_mode_t st;
        sel = c[1] & (~c[2] | kb);
        m = (c[5] | ~c[3]) ? REG_OFF :
            (c[4] | ~c[0]) ? REG_STANDBY : REG_ACTIVE;
        st = c[5] ? STOP_DEEPEST : c[4] ? STOP_SHALLOW : STOP_RUN;
        return {st, kb, tk, m, c[0] & sel & (c[2] | vb)};
    endfunction

    function automatic int slot_of(input logic [2:0] ep, input logic o,
                                   input logic d);
        case (ep)
            3'h0: return int'(o);
            3'h5: return 6 + int'(d);
            3'h6: return 8 + int'(d);
            3'h7: return -1;
            default: return int'(ep) + 1;
        endcase
    endfunction

    always @(posedge core_clk_i)
        rd_pend <= re_i;

    always @(negedge core_clk_i)
        if (rd_pend === 1'b1)
            chk(rdata_o, exp_q.pop_front());

    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        seed = 32'hEBA3;
        error_cnt = 0;
        total_checks = 0;
        rst_i = 1'b1;
        addr_i = 9'h000;
        wdata_i = 8'h00;
        we_i = 1'b0;
        re_i = 1'b0;
        kbi_vbus_i = 1'b0;
        vbus_i = 1'b0;
        repeat (10) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        rd(`SW_CTRL_OFS, 8'h00);
        rd(`SW_STAT_OFS, stat_exp(8'h00, 1'b0, 1'b0, 2'b00));
        rd(9'h1FF, 8'h00);
        for (int i = 0; i < 32; i++)
        begin
            addrs[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            mem[addrs[i]] = 8'($random(seed));
            wr({1'b0, addrs[i]}, mem[addrs[i]]);
        end
        for (int i = 0; i < 32; i++)
            rd({1'b0, addrs[i]}, mem[addrs[i]]);
        for (int i = 0; i < 256; i++)
        begin
            wr(`SW_CTRL_OFS, {2'b00, i[5:0]});
            wr(`SW_STAT_OFS, 8'hFF);
            vbus_i     <= i[6];
            kbi_vbus_i <= i[7];
            e = stat_exp({2'b00, i[5:0]}, i[6], i[7], 2'b00);
            idle(8);
            @(negedge core_clk_i);
            chk({7'h00, pullup_en_o}, {7'h00, e[0]});
            chk({6'h00, reg_mode_o}, {6'h00, e[2:1]});
            chk({6'h00, stop_mode_o}, {6'h00, e[7:6]});
            @(posedge core_clk_i);
            rd(`SW_CTRL_OFS, {2'b00, i[5:0]});
            rd(`SW_STAT_OFS, e);
        end
        wr(`SW_CTRL_OFS, 8'h09);
        vbus_i     <= 1'b0;
        kbi_vbus_i <= 1'b0;
        idle(8);
        for (int k = 0; k < 32; k++)
        begin
            s = slot_of(k[2:0], k[3], k[4]);
            b = 8'($random(seed));
            if (s >= 0)
                wr(9'(s * 3), b);
            wr(`SW_TOKEN_OFS, {3'b000, k[4:0]});
            idle(2);
            e = stat_exp(8'h09, 1'b0, 1'b0, (s < 0) ? 2'b10 : {1'b0, b[7]});
            rd(`SW_STAT_OFS, e);
            if (s >= 0)
            begin
                wr(`SW_TOKEN_OFS, {3'b100, k[4:0]});
                rd(9'(s * 3), {1'b0, b[6:0]});
            end
        end
        wr(`SW_BDSEL_OFS, 8'h24);
        wr(`SW_SIEDAT_OFS, 8'h3C);
        wr(`SW_SIEADR_OFS, 8'h40);
        for (int i = 0; i < 4; i++)
            wr(`SW_SIEDAT_OFS, 8'(8'hC0 + i));
        wr(9'h060, 8'h77);
        idle(3);
        rd(9'h00E, 8'h3C);
        for (int i = 0; i < 4; i++)
            rd(9'(9'h040 + i), 8'(8'hC0 + i));
        rd(9'h060, 8'h77);
        // Engine reads: plain mode steps the pointer, descriptor mode not
        wr(`SW_SIEADR_OFS, 8'h41);
        rd(`SW_SIEDAT_OFS, 8'hC1);
        rd(`SW_SIEDAT_OFS, 8'hC2);
        rd(`SW_SIEADR_OFS, 8'h43);
        wr(`SW_BDSEL_OFS, 8'h24);
        rd(`SW_SIEDAT_OFS, 8'h3C);
        rd(`SW_SIEDAT_OFS, 8'h3C);
        // Engine data write while disabled must neither land nor step
        wr(`SW_CTRL_OFS, 8'h08);
        wr(`SW_SIEADR_OFS, 8'h50);
        wr(9'h050, 8'hA5);
        wr(`SW_SIEDAT_OFS, 8'h11);
        rd(9'h050, 8'hA5);
        wr(`SW_CTRL_OFS, 8'h09);
        idle(2);
        wr(`SW_SIEDAT_OFS, 8'h22);
        idle(3);
        rd(9'h050, 8'h22);
        idle(3);
        report_and_stop();
    end
endmodule

`default_nettype wire
